// ---- kde_entry.sv ----
// Keypad command interpreter for manual data register entry
// Summary of operation
// - Panel address is register number plus 1100
// - Entry key discards shown value, accepts digits
// - Two-byte store on plus advances address by two
// - BCD nibbles display as decimal digits
// - Nibbles ten to fourteen show fixed glyphs, fifteen shows blank
// - Writes only reach writable RAM area
// - Plus stores byte, advances address by one in single-byte view
`timescale 1ns/1ps
module kde_entry
#(
    parameter int unsigned REG_COUNT = 8192
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Keypad, raw from panel pins
    input wire logic key_stb,
    input wire logic [3:0] key_code,
    input wire logic [3:0] key_digit,
    // Data register RAM port
    output logic ram_we,
    output logic [12:0] ram_addr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire logic ram_writable,
    // Display
    output logic [13:0] disp_addr,
    output logic disp_pair,
    output logic [27:0] disp_seg
);
    import kde_pkg::*;

    // Elaboration check: the RAM index is 13 bits and a pair needs two registers
    if (REG_COUNT < 2 || REG_COUNT > 8192)
    begin : g_bad_count
        $error("kde_entry: REG_COUNT out of range");
    end

    // Pin synchronisers, stage one read only by stage two
    logic stb_s1_q, stb_s2_q, stb_s3_q;
    logic [7:0] key_s1_q, key_s2_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stb_s1_q <= 1'b0;
            stb_s2_q <= 1'b0;
            stb_s3_q <= 1'b0;
            key_s1_q <= 8'h00;
            key_s2_q <= 8'h00;
        end
        else
        begin
            stb_s1_q <= key_stb;
            stb_s2_q <= stb_s1_q;
            stb_s3_q <= stb_s2_q;
            key_s1_q <= {key_code, key_digit};
            key_s2_q <= key_s1_q;
        end
    end

    // One pulse per key press; code sampled with the strobe settled
    logic key_ev;
    kde_key_t key;
    logic [3:0] dig;
    assign key_ev = stb_s2_q & ~stb_s3_q;
    assign key = kde_key_t'(key_s2_q[7:4]);
    assign dig = key_s2_q[3:0];

    // Dialogue state
    kde_state_t st_q;
    logic [13:0] addr_q; // Selected panel address
    logic pair_q; // Two-byte view
    logic pend_q; // Value pending commit
    logic [15:0] acc_q; // Keyed value, binary
    logic [15:0] bcd_q; // Keyed digits for display
    logic [1:0] wr_q; // Remaining store bytes
    logic [15:0] wval_q; // Value being stored
    logic rd_ph_q; // Read slot: high means predecessor fetched

    // Register index of current address
    logic [13:0] reg_idx;
    logic in_area;
    assign reg_idx = addr_q - KDE_DR_OFFSET;
    assign in_area = (addr_q >= KDE_DR_OFFSET) &&
        (reg_idx < 14'(REG_COUNT));

    // Commit happens on these keys when a value is pending
    logic commit;
    assign commit = key_ev && pend_q && (key == KDE_KEY_PLUS || key == KDE_KEY_MINUS ||
        key == KDE_KEY_ADDR || key == KDE_KEY_ENTRY);

    // Step size after a store or browse
    logic [13:0] step;
    assign step = pair_q ? KDE_STEP_PAIR : KDE_STEP_ONE;

    // Key interpreter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= KDE_ST_IDLE;
            addr_q <= KDE_DR_OFFSET;
            pair_q <= 1'b0;
            pend_q <= 1'b0;
            acc_q <= 16'h0000;
            bcd_q <= 16'h0000;
        end
        else if (key_ev)
        begin
            case (key)
                KDE_KEY_ADDR:
                begin
                    // New address typed from zero
                    st_q <= KDE_ST_ADDR;
                    addr_q <= 14'h0000;
                    pair_q <= 1'b0;
                    pend_q <= 1'b0;
                end
                KDE_KEY_ENTRY:
                begin
                    // Old value discarded, digits collect afresh
                    st_q <= KDE_ST_VALUE;
                    acc_q <= 16'h0000;
                    bcd_q <= 16'h0000;
                    pend_q <= 1'b1;
                end
                KDE_KEY_CONV:
                begin
                    if (st_q == KDE_ST_VALUE)
                    begin
                        // Correction: restart the digit sequence
                        acc_q <= 16'h0000;
                        bcd_q <= 16'h0000;
                    end
                    else
                        pair_q <= ~pair_q;
                end
                KDE_KEY_CLEAR:
                begin
                    acc_q <= 16'h0000;
                    bcd_q <= 16'h0000;
                end
                KDE_KEY_PLUS:
                begin
                    addr_q <= addr_q + step;
                    pend_q <= 1'b0;
                    st_q <= KDE_ST_IDLE;
                end
                KDE_KEY_MINUS:
                begin
                    addr_q <= addr_q - step;
                    pend_q <= 1'b0;
                    st_q <= KDE_ST_IDLE;
                end
                KDE_KEY_DIGIT:
                begin
                    if (st_q == KDE_ST_ADDR)
                        addr_q <= 14'(addr_q * 14'd10 + {10'h000, dig});
                    else if (st_q == KDE_ST_VALUE && dig < 4'ha)
                    begin
                        // Binary value wraps past the view width; limitation of the panel
                        acc_q <= 16'(acc_q * 16'd10 + {12'h000, dig});
                        bcd_q <= {bcd_q[11:0], dig};
                    end
                end
                default:
                begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // Store sequencer: low byte at selected register, high byte at predecessor
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= 2'd0;
            wval_q <= 16'h0000;
            ram_addr <= 13'h0000;
        end
        else if (commit && in_area)
        begin
            wr_q <= pair_q ? 2'd2 : 2'd1;
            wval_q <= pair_q ? acc_q : {8'h00, acc_q[7:0]};
            ram_addr <= reg_idx[12:0];
        end
        else if (wr_q != 2'd0)
        begin
            wr_q <= wr_q - 2'd1;
            wval_q <= {8'h00, wval_q[15:8]};
            ram_addr <= ram_addr - 13'h0001;
        end
        else if (in_area)
            // Fetch address follows the read slot; predecessor feeds the high byte
            ram_addr <= rd_ph_q ? reg_idx[12:0] : reg_idx[12:0] - 13'h0001;
    end

    // Write only where RAM backs the area
    assign ram_we = (wr_q != 2'd0) && ram_writable;
    assign ram_wdata = wval_q[7:0];

    // Shown value: pair view reads predecessor as high byte
    logic [7:0] lo_q, hi_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
            rd_ph_q <= 1'b0;
        end
        else if (wr_q == 2'd0)
        begin
            // Alternate fetch slots; ram_addr swaps between register and predecessor
            rd_ph_q <= ~rd_ph_q;
            if (rd_ph_q)
                hi_q <= ram_rdata;
            else
                lo_q <= ram_rdata;
        end
    end

    // Display nibbles from keyed digits or stored binary
    logic [15:0] shown;
    assign shown = (st_q == KDE_ST_VALUE) ? bcd_q :
        (pair_q ? {hi_q, lo_q} : {8'h00, lo_q});

    logic [27:0] seg_w;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_dig
            kde_seg u_seg
            (
                .nib(shown[gi*4 +: 4]),
                .seg(seg_w[gi*7 +: 7])
            );
        end
    endgenerate

    // Registered display outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disp_seg <= 28'h0000000;
            disp_addr <= KDE_DR_OFFSET;
            disp_pair <= 1'b0;
        end
        else
        begin
            disp_seg <= seg_w;
            disp_addr <= addr_q;
            disp_pair <= pair_q;
        end
    end
endmodule // kde_entry

// ---- kde_entry_assertions.sv ----
// Checker watching the ports of the entry block
`timescale 1ns/1ps
module kde_entry_assertions
#(
    parameter int unsigned REG_COUNT = 8192
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic key_stb,
    input wire logic [3:0] key_code,
    input wire logic [3:0] key_digit,
    input wire logic ram_we,
    input wire logic [12:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire logic ram_writable,
    input wire logic [13:0] disp_addr,
    input wire logic disp_pair,
    input wire logic [27:0] disp_seg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    we_needs_ram_a: assert property (ram_we |-> ram_writable)
        else $error("write while area not writable");
    we_in_area_a: assert property (ram_we |-> 32'(ram_addr) < REG_COUNT)
        else $error("write outside register area");
    pair_max_two_a: assert property (ram_we ##1 ram_we |=> !ram_we)
        else $error("more than two bytes per store");
    pair_down_a: assert property (ram_we ##1 ram_we |-> ram_addr == $past(ram_addr) - 13'h1)
        else $error("second byte not at lower index");
    quiet_no_we_a: assert property (!key_stb [*8] |-> !ram_we)
        else $error("write without a key");
    quiet_addr_a: assert property (!key_stb [*8] |-> $stable(disp_addr))
        else $error("address moved without a key");
    quiet_seg_a: assert property (!key_stb [*8] |-> $stable(disp_seg))
        else $error("segments moved without a key");
    quiet_pair_a: assert property (!key_stb [*8] |-> $stable(disp_pair))
        else $error("pair view moved without a key");
endmodule // kde_entry_assertions
bind kde_entry kde_entry_assertions #(.REG_COUNT(REG_COUNT)) u_chk (.*);

// ---- kde_pkg.sv ----
// Package of constants and types for the keypad data register entry block
package kde_pkg;
    // Panel address offset of the data register area
    localparam logic [13:0] KDE_DR_OFFSET = 14'h044c;
    // Key codes from the keypad scanner
    typedef enum logic [3:0] {
        KDE_KEY_DIGIT = 4'h0,
        KDE_KEY_ADDR = 4'h1,
        KDE_KEY_ENTRY = 4'h2,
        KDE_KEY_CONV = 4'h3,
        KDE_KEY_PLUS = 4'h4,
        KDE_KEY_MINUS = 4'h5,
        KDE_KEY_CLEAR = 4'h6
    } kde_key_t;
    // Operator dialogue states, Gray coded
    typedef enum logic [1:0] {
        KDE_ST_IDLE = 2'b00,
        KDE_ST_ADDR = 2'b01,
        KDE_ST_VALUE = 2'b11
    } kde_state_t;
    // Blank glyph (segments g..a, active high)
    localparam logic [6:0] KDE_SEG_BLANK = 7'h00;
    // Two-byte mode step
    localparam logic [13:0] KDE_STEP_PAIR = 14'h0002;
    // Single-byte mode step
    localparam logic [13:0] KDE_STEP_ONE = 14'h0001;
endpackage

// ---- kde_ram_model.sv ----
// Behavioural data register RAM standing behind the entry block
`timescale 1ns/1ps
module kde_ram_model
(
    // Clock
    input wire logic clk,
    // Port from the block
    input wire logic we,
    input wire logic [12:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Bench control of the RAM area
    input wire logic wr_ok,
    output logic writable
);
    // Storage, preset to a known pattern so lost writes show
    logic [7:0] mem [0:8191];
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = i[7:0] ^ 8'h5a;
    end
    // Read is combinational, as the block assumes
    assign rdata = mem[addr];
    assign writable = wr_ok;
    // Takes every write strobe, so a store into a protected area would show
    always @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
    end
endmodule // kde_ram_model

// ---- kde_seg.sv ----
// Nibble to seven-segment glyph decoder
`timescale 1ns/1ps
module kde_seg
(
    // Nibble in
    input wire logic [3:0] nib,
    // Segments g..a, active high
    output logic [6:0] seg
);
    import kde_pkg::*;

    // Decimal digits for BCD nibbles, fixed glyphs for ten to fourteen, blank for fifteen
    always_comb
    begin
        case (nib)
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            4'ha: seg = 7'h08;
            4'hb: seg = 7'h79;
            4'hc: seg = 7'h58;
            4'hd: seg = 7'h5c;
            4'he: seg = 7'h7c;
            default: seg = KDE_SEG_BLANK;
        endcase
    end
endmodule // kde_seg

// ---- tb_keypad_data_register_entry.sv ----
// Self-checking bench for the keypad data register entry block
`timescale 1ns/1ps
module tb_keypad_data_register_entry;
    import kde_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic key_stb = 1'b0;
    logic [3:0] key_code = 4'h0;
    logic [3:0] key_digit = 4'h0;
    logic ram_we, ram_writable, disp_pair, wr_ok = 1'b1;
    logic [12:0] ram_addr;
    logic [7:0] ram_wdata, ram_rdata;
    logic [13:0] disp_addr;
    logic [27:0] disp_seg;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    kde_entry u_dut (.clk(clk), .rst_n(rst_n), .key_stb(key_stb), .key_code(key_code),
        .key_digit(key_digit), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .ram_writable(ram_writable), .disp_addr(disp_addr),
        .disp_pair(disp_pair), .disp_seg(disp_seg));
    kde_ram_model u_ram (.clk(clk), .we(ram_we), .addr(ram_addr), .wdata(ram_wdata),
        .rdata(ram_rdata), .wr_ok(wr_ok), .writable(ram_writable));
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // One key press, held and released long enough for the synchroniser
    task automatic press(input logic [3:0] c, input logic [3:0] d);
        @(negedge clk);
        key_code = c;
        key_digit = d;
        key_stb = 1'b1;
        repeat (5) @(negedge clk);
        key_stb = 1'b0;
        // Long idle lets the quiet-panel checks see a settled display
        repeat (9) @(negedge clk);
    endtask
    // Types a key string: A address, E entry, C convert, + plus, - minus
    task automatic keys(input string s);
        byte ch;
        for (int i = 0; i < s.len(); i++)
        begin
            ch = s[i];
            if (ch >= "0" && ch <= "9")
                press(KDE_KEY_DIGIT, 4'(ch - "0"));
            else if (ch == "A")
                press(KDE_KEY_ADDR, 4'h0);
            else if (ch == "E")
                press(KDE_KEY_ENTRY, 4'h0);
            else if (ch == "C")
                press(KDE_KEY_CONV, 4'h0);
            else if (ch == "+")
                press(KDE_KEY_PLUS, 4'h0);
            else
                press(KDE_KEY_MINUS, 4'h0);
        end
    endtask
    task automatic t_reset();
        chk(disp_addr === 14'd1100 && disp_pair === 1'b0, "reset view");
        $display("t_reset done");
    endtask
    task automatic t_single();
        keys("A7436E48");
        chk(disp_seg[13:0] === 14'h337f, "keyed digits 48 not shown");
        keys("+");
        chk(u_ram.mem[6336] === 8'h30, "byte store");
        chk(u_ram.mem[6337] === (8'hc1 ^ 8'h5a), "neighbour touched");
        chk(disp_addr === 14'd7437, "step by one");
        $display("t_single done");
    endtask
    task automatic t_pair();
        keys("A7457CE1487C01487+");
        chk(u_ram.mem[6357] === 8'hcf && u_ram.mem[6356] === 8'h05, "pair store");
        chk(disp_addr === 14'd7459, "step by two");
        keys("A7457C");
        chk(disp_seg[6:0] === KDE_SEG_BLANK, "nibble 15 not blank");
        chk(disp_seg[27:14] === {7'h3f, 7'h6d}, "pair view digits");
        $display("t_pair done");
    endtask
    task automatic t_minus();
        keys("A7500E7-");
        chk(u_ram.mem[6400] === 8'h07 && disp_addr === 14'd7499, "minus single");
        keys("A7600CE00300-");
        chk(u_ram.mem[6500] === 8'h2c && u_ram.mem[6499] === 8'h01, "minus pair");
        chk(disp_addr === 14'd7598, "minus step two");
        $display("t_minus done");
    endtask
    task automatic t_commit();
        keys("A7436E9A7000");
        chk(u_ram.mem[6336] === 8'h09, "address key commit");
        chk(disp_addr === 14'd7000, "new address");
        keys("A7436E5E");
        chk(u_ram.mem[6336] === 8'h05, "entry key commit");
        $display("t_commit done");
    endtask
    task automatic t_protect();
        wr_ok = 1'b0;
        keys("A7436E55+");
        chk(u_ram.mem[6336] === 8'h05, "store into read-only area");
        wr_ok = 1'b1;
        $display("t_protect done");
    endtask
    task automatic summarize();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hang short well beyond the roughly 1250 cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_single();
        t_pair();
        t_minus();
        t_commit();
        t_protect();
        summarize();
    end
endmodule // tb_keypad_data_register_entry
